/* design/brc_pkg.sv */
// Package with constants, register map and carrier types for the bridge reset control
package brc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing constants
    localparam int unsigned REF_CLK_KHZ      = 64000;                    // External reference rate
    localparam int unsigned SYS_CLK_KHZ      = 50000;                    // Core clock rate
    localparam int unsigned VME_RST_HOLD_MS  = 256;                      // SYSRST hold after last source
    localparam int unsigned PCI_RST_HOLD_MS  = 5;                        // Least local PCI reset width
    localparam int unsigned VME_RST_TICKS    = VME_RST_HOLD_MS * REF_CLK_KHZ; // Rounded up: exact
    localparam int unsigned PCI_RST_TICKS    = PCI_RST_HOLD_MS * REF_CLK_KHZ; // Rounded up: exact
    localparam int unsigned CNT_W            = 24;                       // Width of hold counters

    ////////////////////////////////////////////////////////////////////////////
    // Register indices on the local register port
    localparam logic [1:0] IDX_MISC_CONTROL  = 2'h0;
    localparam logic [1:0] IDX_CSR_BIT_CLEAR = 2'h1;
    localparam logic [1:0] IDX_CSR_BIT_SET   = 2'h2;

    // Field positions in misc_control
    localparam int unsigned MISC_SW_PCI_RST  = 0;                        // sw_pci_reset_bit
    localparam int unsigned MISC_SW_VME_RST  = 1;                        // sw_request_n_a_bit
    localparam int unsigned MISC_BUS64       = 8;                        // Read-only bus width status
    localparam int unsigned MISC_SYSCON      = 9;                        // Read-only system controller status

    // Field positions shared by csr_bit_set and csr_bit_clear
    localparam int unsigned CSR_FAIL         = 5;
    localparam int unsigned CSR_SYSFAIL      = 6;
    localparam int unsigned CSR_RESET        = 7;

    // Reset values
    localparam logic        SYSFAIL_RST      = 1'b0;
    localparam logic        FAIL_RST         = 1'b0;
    localparam logic        BOARD_RST_RST    = 1'b0;
    localparam logic [31:0] RDATA_RST        = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic por_n;                                                     // Power-on reset, low active
        logic pci_rst_n;                                                 // PCI reset input, low active
        logic vme_in_n;                                                  // VMEbus reset input, low active
        logic req_n;                                                     // VMEbus reset request, low active
        logic req64_n;                                                   // PCI 64-bit request pin
        logic bg3_n;                                                     // Bus grant 3 input
        logic ref_clk;                                                   // External 64 MHz reference
    } brc_pins_t;

    typedef struct packed {
        logic clk_srv;                                                   // Clock services group
        logic vme_srv;                                                   // Arbiter, timer, CSR, power-up machine
        logic gen_srv;                                                   // Most registers and state machines
    } brc_grp_t;

    typedef struct packed {
        logic        wr;                                                 // Write strobe
        logic        rd;                                                 // Read strobe
        logic [1:0]  idx;                                                // Register index
        logic [31:0] wdata;                                              // Write data
    } brc_req_t;

endpackage

/* design/brc_reset_ctrl.sv */
// Reset sequencer of the bus bridge: source decode, output stretching, software reset bits
`timescale 1ns/100ps

module brc_reset_ctrl #(
    parameter int unsigned          OPT_W     = 32,                      // Number of power-up option pins
    parameter logic [brc_pkg::CNT_W-1:0] VME_HOLD = brc_pkg::CNT_W'(brc_pkg::VME_RST_TICKS),
    parameter logic [brc_pkg::CNT_W-1:0] PCI_HOLD = brc_pkg::CNT_W'(brc_pkg::PCI_RST_TICKS)
) (
    input  wire logic               clk_i,                               // 50 MHz core clock
    input  wire logic               sys_rst_i,                           // Async reset, high active
    input  wire brc_pkg::brc_pins_t pins_i,                              // Reset and strap pins
    input  wire logic [OPT_W-1:0]   option_pins_i,                       // Power-up option pins
    input  wire logic               trst_n_i,                            // JTAG test reset, low active
    input  wire brc_pkg::brc_req_t  req_i,                               // Local register request
    output logic [31:0]             rdata_o,                             // Read data, one cycle after rd
    output brc_pkg::brc_grp_t       grp_rst_o,                           // Internal group resets, high active
    output logic                    tap_rst_o,                           // TAP controller reset, high active
    output logic                    local_pci_reset_out_n_o,             // Local PCI reset, low active
    output logic                    vme_system_reset_out_o,              // VMEbus system reset drive
    output logic                    sysfail_out_o,                       // VMEbus SYSFAIL drive
    output logic [OPT_W-1:0]        options_o,                           // Active power-up options
    output logic                    bus64_o,                             // PCI bus width is 64 bit
    output logic                    syscon_en_o                          // System controller enabled
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    brc_pkg::brc_pins_t pin_meta_r;                                      // First stage, read by second only
    brc_pkg::brc_pins_t pin_sync_r;                                      // Second stage
    logic [OPT_W-1:0]   opt_meta_r;                                      // First stage of option pins
    logic [OPT_W-1:0]   opt_sync_r;                                      // Second stage of option pins
    logic               ref_prev_r;                                      // Reference level one cycle ago

    // Two flops ahead of any logic, pins are from outside this domain
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_meta_r <= '1;
            pin_sync_r <= '1;
            opt_meta_r <= '0;
            opt_sync_r <= '0;
            ref_prev_r <= 1'b1;                                          // Same as synced level, no false tick
        end else begin
            pin_meta_r <= pins_i;
            pin_sync_r <= pin_meta_r;
            opt_meta_r <= option_pins_i;
            opt_sync_r <= opt_meta_r;
            ref_prev_r <= pin_sync_r.ref_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded reset sources
    wire por_act  = ~pin_sync_r.por_n;                                   // Power-on reset active
    wire pci_act  = ~pin_sync_r.pci_rst_n;                               // PCI reset input active
    wire vme_act  = ~pin_sync_r.vme_in_n;                                // VMEbus reset input active
    wire req_act  = ~pin_sync_r.req_n;                                   // VMEbus reset request active
    // Reference edge as a one-cycle enable; the reference is faster than clk_i,
    // so edges alias and hold times run long, never short, against the nominal figure
    wire ref_tick = pin_sync_r.ref_clk & ~ref_prev_r;

    // Register decode
    wire wr_misc  = req_i.wr & (req_i.idx == brc_pkg::IDX_MISC_CONTROL);
    wire wr_set   = req_i.wr & (req_i.idx == brc_pkg::IDX_CSR_BIT_SET);
    wire wr_clr   = req_i.wr & (req_i.idx == brc_pkg::IDX_CSR_BIT_CLEAR);

    // Software one-shots: writes of zero do nothing
    wire sw_pci_go = wr_misc & req_i.wdata[brc_pkg::MISC_SW_PCI_RST];
    wire sw_vme_go = wr_misc & req_i.wdata[brc_pkg::MISC_SW_VME_RST];

    ////////////////////////////////////////////////////////////////////////////
    // Internal group resets come from pins only; software reaches them only by loopback
    brc_pkg::brc_grp_t grp_nxt;

    assign grp_nxt.clk_srv = por_act;
    assign grp_nxt.vme_srv = por_act | vme_act;
    assign grp_nxt.gen_srv = por_act | pci_act | vme_act;

    // Registered group resets, asserted through async reset until the first clock edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            grp_rst_o <= '1;
        end else begin
            grp_rst_o <= grp_nxt;
        end
    end

    // TAP reset straight from the pin, no clock involved
    assign tap_rst_o = ~trst_n_i;

    ////////////////////////////////////////////////////////////////////////////
    // CSR latches: board reset, SYSFAIL and FAIL, all in the VMEbus services group
    logic board_rst_r;                                                   // Latched board reset request
    logic sysfail_r;                                                     // Latched SYSFAIL drive
    logic fail_r;                                                        // Board failure status flag
    logic board_rst_nxt;
    logic sysfail_nxt;
    logic fail_nxt;

    // Set register asserts, clear register negates; only the VMEbus services group reset overrides them
    assign board_rst_nxt = grp_nxt.vme_srv ? brc_pkg::BOARD_RST_RST :
                           (wr_set & req_i.wdata[brc_pkg::CSR_RESET]) ? 1'b1 :
                           (wr_clr & req_i.wdata[brc_pkg::CSR_RESET]) ? 1'b0 : board_rst_r;
    assign sysfail_nxt   = grp_nxt.vme_srv ? brc_pkg::SYSFAIL_RST :
                           (wr_set & req_i.wdata[brc_pkg::CSR_SYSFAIL]) ? 1'b1 :
                           (wr_clr & req_i.wdata[brc_pkg::CSR_SYSFAIL]) ? 1'b0 : sysfail_r;
    assign fail_nxt      = grp_nxt.vme_srv ? brc_pkg::FAIL_RST :
                           (wr_set & req_i.wdata[brc_pkg::CSR_FAIL]) ? 1'b1 :
                           (wr_clr & req_i.wdata[brc_pkg::CSR_FAIL]) ? 1'b0 : fail_r;

    // Latch update
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            board_rst_r <= brc_pkg::BOARD_RST_RST;
            sysfail_r   <= brc_pkg::SYSFAIL_RST;
            fail_r      <= brc_pkg::FAIL_RST;
        end else begin
            board_rst_r <= board_rst_nxt;
            sysfail_r   <= sysfail_nxt;
            fail_r      <= fail_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // VMEbus system reset: sources and 256 ms hold on the reference
    logic [brc_pkg::CNT_W-1:0] vme_cnt_r;                                // Hold ticks left
    logic [brc_pkg::CNT_W-1:0] vme_cnt_nxt;
    logic                      vme_out_r;
    logic                      vme_out_nxt;

    wire vme_src = por_act | req_act | sw_vme_go;

    // Reload while a source stands, count down on reference ticks after
    assign vme_cnt_nxt = vme_src ? VME_HOLD :
                         (ref_tick && vme_cnt_r != '0) ? vme_cnt_r - 1'b1 : vme_cnt_r;
    assign vme_out_nxt = vme_src | (vme_cnt_r != '0);

    ////////////////////////////////////////////////////////////////////////////
    // Local PCI reset: stretched sources plus unstretched VMEbus input
    logic [brc_pkg::CNT_W-1:0] pci_cnt_r;                                // Stretch ticks left
    logic [brc_pkg::CNT_W-1:0] pci_cnt_nxt;
    logic                      pci_out_r;                                // High while PCI reset asserted
    logic                      pci_out_nxt;

    wire pci_src = por_act | sw_pci_go | board_rst_r;

    // Stretch applies to every source except the VMEbus reset input
    assign pci_cnt_nxt = pci_src ? PCI_HOLD :
                         (ref_tick && pci_cnt_r != '0) ? pci_cnt_r - 1'b1 : pci_cnt_r;
    // VMEbus input passes straight through; the request-to-PCI loop is the board's to break
    assign pci_out_nxt = pci_src | (pci_cnt_r != '0) | vme_act;

    // Counters and output flops
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vme_cnt_r <= '0;
            vme_out_r <= 1'b1;
            pci_cnt_r <= '0;
            pci_out_r <= 1'b1;
        end else begin
            vme_cnt_r <= vme_cnt_nxt;
            vme_out_r <= vme_out_nxt;
            pci_cnt_r <= pci_cnt_nxt;
            pci_out_r <= pci_out_nxt;
        end
    end

    assign vme_system_reset_out_o  = vme_out_r;
    assign local_pci_reset_out_n_o = ~pci_out_r;
    assign sysfail_out_o           = sysfail_r;

    ////////////////////////////////////////////////////////////////////////////
    // Power-up options
    logic [OPT_W-1:0] opt_latch_r;                                       // Pin values caught at power-on
    logic [OPT_W-1:0] opt_r;                                             // Options in use
    logic             any_rst_r;                                         // Any reset active last cycle
    logic             bus64_r;
    logic             syscon_r;

    wire any_rst  = por_act | pci_act | vme_act;
    wire rst_done = any_rst_r & ~any_rst;                                // Release of the last source

    // Pins tracked during power-on, so the value at its release stays
    // Options loaded at release; non-power-on resets reuse the power-on latch
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            opt_latch_r <= '0;
            opt_r       <= '0;
            any_rst_r   <= 1'b0;
        end else begin
            any_rst_r <= any_rst;
            if (por_act) begin
                opt_latch_r <= opt_sync_r;
            end
            if (rst_done) begin
                opt_r <= por_act ? opt_sync_r : opt_latch_r;
            end
        end
    end

    // Bus width on every PCI reset, syscon on every VMEbus reset
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus64_r  <= 1'b0;
            syscon_r <= 1'b0;
        end else begin
            if (pci_act) begin
                bus64_r <= ~pin_sync_r.req64_n;
            end
            if (por_act | vme_act) begin
                syscon_r <= ~pin_sync_r.bg3_n;
            end
        end
    end

    assign options_o   = opt_r;
    assign bus64_o     = bus64_r;
    assign syscon_en_o = syscon_r;

    ////////////////////////////////////////////////////////////////////////////
    // Read path: software bits read zero, CSR reset and SYSFAIL bits show live output state, FAIL shows its flag
    logic [31:0] rd_misc;
    logic [31:0] rd_csr;
    logic [31:0] rd_mux;
    logic [31:0] rdata_r;

    // Misc control read image
    always_comb begin
        rd_misc = '0;
        rd_misc[brc_pkg::MISC_SW_PCI_RST] = 1'b0;
        rd_misc[brc_pkg::MISC_SW_VME_RST] = 1'b0;
        rd_misc[brc_pkg::MISC_BUS64]      = bus64_r;
        rd_misc[brc_pkg::MISC_SYSCON]     = syscon_r;
    end

    // Both CSR registers read the same image
    always_comb begin
        rd_csr = '0;
        rd_csr[brc_pkg::CSR_RESET]   = pci_out_r;
        rd_csr[brc_pkg::CSR_SYSFAIL] = sysfail_r;
        rd_csr[brc_pkg::CSR_FAIL]    = fail_r;
    end

    // Unmapped index reads zero
    assign rd_mux = (req_i.idx == brc_pkg::IDX_MISC_CONTROL)  ? rd_misc :
                    (req_i.idx == brc_pkg::IDX_CSR_BIT_SET)   ? rd_csr  :
                    (req_i.idx == brc_pkg::IDX_CSR_BIT_CLEAR) ? rd_csr  : '0;

    // Read data flop, holds until the next read
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r <= brc_pkg::RDATA_RST;
        end else if (req_i.rd) begin
            rdata_r <= rd_mux;
        end
    end

    assign rdata_o = rdata_r;

endmodule

/* testbench/brc_pins_model.sv */
// Far-side model: reset sources, straps and the free-running reference oscillator
`timescale 1ns/100ps
module brc_pins_model (
    input  wire logic [3:0]         act_i,      // Active sources: power-on, PCI, VMEbus input, request
    input  wire logic [1:0]         strap_n_i,  // Strap levels: 64-bit request, bus grant 3
    output wire brc_pkg::brc_pins_t pins_o      // Pins as the bridge sees them
);
    logic ref_r = 1'b0;  // Slowed so each reference period gives one tick
    initial forever #40 ref_r = ~ref_r;
    // Reset lines have pull-ups, so a released source reads high
    // Request and PCI reset stay separate nets, no loop back
    assign pins_o = '{por_n: ~act_i[3], pci_rst_n: ~act_i[2], vme_in_n: ~act_i[1], req_n: ~act_i[0],
                      req64_n: strap_n_i[1], bg3_n: strap_n_i[0], ref_clk: ref_r};
endmodule

/* testbench/brc_reset_ctrl_asserts.sv */
// Assertion checker for the bridge reset control, bound to its top module
`timescale 1ns/100ps
module brc_reset_ctrl_asserts #(
    parameter int unsigned               OPT_W    = 32,
    parameter logic [brc_pkg::CNT_W-1:0] VME_HOLD = brc_pkg::CNT_W'(brc_pkg::VME_RST_TICKS),
    parameter logic [brc_pkg::CNT_W-1:0] PCI_HOLD = brc_pkg::CNT_W'(brc_pkg::PCI_RST_TICKS)
) (
    input wire logic               clk_i,
    input wire logic               sys_rst_i,
    input wire brc_pkg::brc_pins_t pins_i,
    input wire logic [OPT_W-1:0]   option_pins_i,
    input wire logic               trst_n_i,
    input wire brc_pkg::brc_req_t  req_i,
    input wire logic [31:0]        rdata_o,
    input wire brc_pkg::brc_grp_t  grp_rst_o,
    input wire logic               tap_rst_o,
    input wire logic               local_pci_reset_out_n_o,
    input wire logic               vme_system_reset_out_o,
    input wire logic               sysfail_out_o,
    input wire logic [OPT_W-1:0]   options_o,
    input wire logic               bus64_o,
    input wire logic               syscon_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////
    logic                      ref_q;     // Reference level one cycle back
    logic                      board_r;   // Mirror of the board reset latch
    logic [brc_pkg::CNT_W-1:0] vme_tk;    // Ticks since last system reset source
    logic [brc_pkg::CNT_W-1:0] pci_tk;    // Ticks since last stretched PCI source
    logic [3:0]                vme_age;   // Cycles since VMEbus reset input was low
    wire tick  = pins_i.ref_clk & ~ref_q;
    wire w0    = req_i.wr && req_i.idx == brc_pkg::IDX_MISC_CONTROL;
    wire w_set = req_i.wr && req_i.idx == brc_pkg::IDX_CSR_BIT_SET;
    wire w_clr = req_i.wr && req_i.idx == brc_pkg::IDX_CSR_BIT_CLEAR;
    wire vme_src = !pins_i.por_n || !pins_i.req_n || (w0 && req_i.wdata[1]);
    wire pci_src = !pins_i.por_n || (w0 && req_i.wdata[0]) || board_r || (w_clr && req_i.wdata[7]);
    // Counters start at their hold so the release of reset looks finished
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ref_q <= 1'b0;
            board_r <= 1'b0;
            vme_tk <= VME_HOLD;
            pci_tk <= PCI_HOLD;
            vme_age <= 4'hF;
        end else begin
            ref_q <= pins_i.ref_clk;
            board_r <= (board_r || (w_set && req_i.wdata[7])) && !(w_clr && req_i.wdata[7]) && !grp_rst_o.vme_srv;
            vme_tk <= vme_src ? '0 : vme_tk + (tick && !(&vme_tk));
            pci_tk <= pci_src ? '0 : pci_tk + (tick && !(&pci_tk));
            vme_age <= !pins_i.vme_in_n ? 4'h0 : vme_age + (vme_age != 4'hF);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_por_resets_all: assert property ((!pins_i.por_n)[*6] |-> grp_rst_o.clk_srv && grp_rst_o.vme_srv
        && grp_rst_o.gen_srv && !local_pci_reset_out_n_o && vme_system_reset_out_o) else $error("power-on reset incomplete");
    a_pci_in_general: assert property ((pins_i.por_n && pins_i.vme_in_n && !pins_i.pci_rst_n)[*6] |->
        grp_rst_o.gen_srv && !grp_rst_o.vme_srv && !grp_rst_o.clk_srv) else $error("PCI reset groups wrong");
    a_vme_in_groups: assert property ((pins_i.por_n && !pins_i.vme_in_n)[*6] |-> grp_rst_o.vme_srv &&
        grp_rst_o.gen_srv && !grp_rst_o.clk_srv && !local_pci_reset_out_n_o) else $error("VMEbus reset groups wrong");
    a_request_drives: assert property ($fell(pins_i.req_n) |-> ##[1:4] vme_system_reset_out_o)
        else $error("request did not drive system reset");
    a_vme_hold_time: assert property ($fell(vme_system_reset_out_o) |->
        vme_tk >= VME_HOLD - 1 && vme_tk <= VME_HOLD + 2) else $error("system reset hold wrong");
    a_pci_hold_time: assert property ($rose(local_pci_reset_out_n_o) |->
        pci_tk >= PCI_HOLD - 1 || vme_age < 4'h8) else $error("PCI reset released early");
    a_tap_async: assert property (tap_rst_o == !trst_n_i) else $error("TAP reset does not follow input");
    a_board_set: assert property (w_set && req_i.wdata[7] && !grp_rst_o.vme_srv |-> ##2
        !local_pci_reset_out_n_o) else $error("board set did not assert PCI reset");
    a_sysfail_set: assert property (w_set && req_i.wdata[6] && !grp_rst_o.vme_srv |-> ##2 sysfail_out_o)
        else $error("SYSFAIL set failed");
    a_sysfail_clear: assert property (w_clr && req_i.wdata[6] |-> ##2 !sysfail_out_o)
        else $error("SYSFAIL clear failed");
    a_sw_bits_zero: assert property (req_i.rd && req_i.idx == brc_pkg::IDX_MISC_CONTROL |=>
        rdata_o[1:0] == 2'h0) else $error("software reset bits read back");
    a_csr_read_state: assert property (req_i.rd && req_i.idx != brc_pkg::IDX_MISC_CONTROL && req_i.idx != 2'h3 |=>
        rdata_o[7] == !$past(local_pci_reset_out_n_o) && rdata_o[6] == $past(sysfail_out_o)) else $error("CSR read wrong");
    c_vme_hold: cover property ($fell(vme_system_reset_out_o));
    c_pci_follow: cover property ($rose(local_pci_reset_out_n_o) && vme_age < 4'h8);
    c_sysfail_off: cover property ($fell(sysfail_out_o));
endmodule

bind brc_reset_ctrl brc_reset_ctrl_asserts #(.OPT_W(OPT_W), .VME_HOLD(VME_HOLD), .PCI_HOLD(PCI_HOLD)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins_i), .option_pins_i(option_pins_i), .trst_n_i(trst_n_i),
    .req_i(req_i), .rdata_o(rdata_o), .grp_rst_o(grp_rst_o), .tap_rst_o(tap_rst_o),
    .local_pci_reset_out_n_o(local_pci_reset_out_n_o), .vme_system_reset_out_o(vme_system_reset_out_o),
    .sysfail_out_o(sysfail_out_o), .options_o(options_o), .bus64_o(bus64_o), .syscon_en_o(syscon_en_o));

/* testbench/brc_reset_ctrl_tb.sv */
// Self-checking testbench of the bridge reset control
`timescale 1ns/100ps
module brc_reset_ctrl_tb;
    localparam logic [23:0] VH = 24'h00_0014;  // Shortened system reset hold, ticks
    localparam logic [23:0] PH = 24'h00_0005;  // Shortened PCI reset hold, ticks
    localparam int PL = 16, PU = 30, VL = 74, VU = 88;  // Cycle windows, four cycles per tick
    logic clk_i = 1'b0, sys_rst_i = 1'b1, trst_n = 1'b1;
    logic [3:0] act = 4'h0;  // Reset sources asked of the model
    logic [1:0] strap = 2'h3;
    logic [31:0] opt = 32'h0000_0000, o1, rdata, opts;
    brc_pkg::brc_req_t req = '0;
    brc_pkg::brc_pins_t pins;
    brc_pkg::brc_grp_t grp;
    logic tap, pci_n, vme_o, sfail, b64, scon, rd_pend = 1'b0;
    logic [31:0] rd_q[$];  // Expected read data, oldest first
    int bad_count = 0, n_compared = 0, n, n2;
    brc_pins_model u_pins (.act_i(act), .strap_n_i(strap), .pins_o(pins));
    brc_reset_ctrl #(.VME_HOLD(VH), .PCI_HOLD(PH)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins), .option_pins_i(opt), .trst_n_i(trst_n),
        .req_i(req), .rdata_o(rdata), .grp_rst_o(grp), .tap_rst_o(tap), .local_pci_reset_out_n_o(pci_n),
        .vme_system_reset_out_o(vme_o), .sysfail_out_o(sfail), .options_o(opts), .bus64_o(b64), .syscon_en_o(scon));
    initial forever #10 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_b(input logic g, input logic e);
        cmp_w({31'h0, g}, {31'h0, e});
    endtask
    // Register cycles: one strobe cycle, then one quiet cycle
    task automatic wr(input logic [1:0] i, input logic [31:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, idx: i, wdata: d};
        @(negedge clk_i) req <= '0;
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [1:0] i, input logic [31:0] e);
        rd_q.push_back(e);
        req <= '{wr: 1'b0, rd: 1'b1, idx: i, wdata: 32'h0000_0000};
        @(negedge clk_i) req <= '0;
        @(negedge clk_i);
    endtask
    // Bounded wait for PCI reset (s=0) or system reset (s=1) to reach v
    task automatic wait_b(input int s, input logic v, output int c);
        c = 0;
        while (((s == 0) ? pci_n : vme_o) !== v) begin
            if (c == 400) begin
                bad_count++;
                end_sim();
            end
            c++;
            @(negedge clk_i);
        end
    endtask
    // Read data lands on the edge that takes the strobe
    always @(posedge clk_i) rd_pend <= req.rd;
    always @(negedge clk_i) if (rd_pend) cmp_w(rdata, rd_q.pop_front());
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(5));
        repeat (5) @(negedge clk_i);
        sys_rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        cmp_w({26'h0, grp, pci_n, vme_o, sfail}, 32'h0000_0004);
        wr(2'h3, $urandom);
        rd(2'h3, 32'h0000_0000);
        // Power-on with random options and both straps low
        opt = $urandom;
        strap = 2'h0;
        act = 4'h8;
        repeat (8) @(negedge clk_i);
        cmp_w({29'h0, grp}, 32'h0000_0007);
        cmp_b(pci_n, 1'b0);
        cmp_b(vme_o, 1'b1);
        act = 4'h0;
        wait_b(0, 1'b1, n);
        cmp_b(n >= PL && n <= PU, 1'b1);
        wait_b(1, 1'b0, n2);
        cmp_b(n + n2 >= VL && n + n2 <= VU, 1'b1);
        cmp_w(opts, opt);
        cmp_b(scon, 1'b1);
        // PCI reset input with new option pins
        o1 = opt;
        opt = ~opt;
        strap = 2'h1;
        act = 4'h4;
        repeat (8) @(negedge clk_i);
        cmp_w({27'h0, grp, pci_n, vme_o}, 32'h0000_0006);
        act = 4'h0;
        repeat (6) @(negedge clk_i);
        cmp_w(opts, o1);
        cmp_b(b64, 1'b1);
        // VMEbus reset input alone, grant strap now high
        act = 4'h2;
        repeat (8) @(negedge clk_i);
        cmp_w({27'h0, grp, pci_n, vme_o}, 32'h0000_000C);
        act = 4'h0;
        wait_b(0, 1'b1, n);
        cmp_b(n <= 6, 1'b1);
        repeat (4) @(negedge clk_i);
        cmp_w(opts, o1);
        cmp_b(scon, 1'b0);
        // Short reset request
        act = 4'h1;
        repeat (3) @(negedge clk_i);
        act = 4'h0;
        wait_b(1, 1'b1, n);
        wait_b(1, 1'b0, n);
        cmp_b(n >= VL - 4 && n <= VU, 1'b1);
        // Software reset bits, zero writes first
        wr(2'h0, 32'h0000_0000);
        repeat (3) @(negedge clk_i);
        cmp_w({30'h0, pci_n, vme_o}, 32'h0000_0002);
        wr(2'h0, 32'h0000_0001);
        wait_b(0, 1'b0, n);
        cmp_w({29'h0, grp}, 32'h0000_0000);
        wait_b(0, 1'b1, n);
        cmp_b(n >= PL - 4 && n <= PU, 1'b1);
        rd(2'h0, 32'h0000_0100);
        wr(2'h0, 32'h0000_0002);
        wait_b(1, 1'b1, n);
        wait_b(1, 1'b0, n);
        cmp_b(n >= VL - 4 && n <= VU, 1'b1);
        // CSR set and clear with the test reset pulsed meanwhile
        wr(2'h2, 32'h0000_00E0);
        repeat (2) @(negedge clk_i);
        cmp_w({26'h0, grp, pci_n, vme_o, sfail}, 32'h0000_0001);
        trst_n = 1'b0;
        #1 cmp_b(tap, 1'b1);
        @(negedge clk_i) trst_n = 1'b1;
        rd(2'h2, 32'h0000_00E0);
        repeat (100) @(negedge clk_i);
        wr(2'h2, 32'h0000_0000);
        wr(2'h1, 32'h0000_0040);
        repeat (2) @(negedge clk_i);
        cmp_w({30'h0, pci_n, sfail}, 32'h0000_0000);
        rd(2'h1, 32'h0000_00A0);
        wr(2'h1, 32'h0000_0080);
        wait_b(0, 1'b1, n);
        cmp_b(n >= PL - 6 && n <= PU, 1'b1);
        wr(2'h1, 32'h0000_0020);
        rd(2'h1, 32'h0000_0000);
        end_sim();
    end
endmodule
